// file: hw/pss_top.sv
`timescale 1ns/1ns
`default_nettype none
`include "pss_consts.svh"
module pss_top
  import pss_pkg::*;
#(
  parameter int unsigned TICK_DIV = `PSS_TICK_DIV
)
(
  input  wire logic       CORE_CLK,
  input  wire logic       RST_N,
  input  wire logic       POR_OK,
  input  wire logic       LOW_SYSTEM_THRESHOLD_OK,
  input  wire logic       HIGH_SYSTEM_THRESHOLD_OK,
  input  wire logic       HOT_DIE,
  input  wire logic       ON_REQ,
  input  wire logic       OFF_REQ,
  input  wire logic       SLEEP_REQ,
  input  wire logic       WAKE_REQ,
  input  wire logic       IRQ_PENDING,
  input  wire logic [1:0] CHECK_POLICY,
  input  wire logic [7:0] FUSE_UPSET,
  input  wire logic       INTEGRITY_ERROR_CLR,
  input  wire logic       SW_WR_EN,
  input  wire logic [7:0] SW_WR_ADDR,
  input  wire logic [7:0] SW_WR_DATA,
  output logic      [2:0] POWER_STATE,
  output logic            SEQ_BUSY,
  output logic            RES_WR_EN,
  output logic      [7:0] RES_WR_ADDR,
  output logic      [7:0] RES_WR_DATA,
  output logic            RES_DEFAULT_LOAD,
  output logic      [7:0] LINK_KEEP_ON,
  output logic            INTEGRITY_ERROR_FLAG
);
  pss_pwr_t                pwr_q;
  pss_pwr_t                pwr_d;
  pss_seq_t                seq_q;
  pss_seq_t                seq_d;
  pss_phase_t              ph_q;
  pss_phase_t              ph_d;
  pss_policy_t             policy;
  logic [`PSS_ROM_AW-1:0]  ptr_q;
  logic [`PSS_ROM_AW-1:0]  ptr_d;
  logic [`PSS_ROM_AW-1:0]  rd_idx_q;
  logic [`PSS_ENT_W-1:0]   rom_word;
  logic [`PSS_TICK_W-1:0]  tick_q;
  logic [7:0]              sig_q;
  logic [7:0]              sig_d;
  logic [7:0]              link_d;
  logic [3:0]              grant;
  logic [3:0]              legal;
  logic                    chk_vld_q;
  logic                    io_limit_q;
  logic                    io_limit_d;
  logic                    seq_wr;
  logic                    hw_load;
  logic                    err_set;
  logic                    start_run;

  wire [7:0] ent_addr  = rom_word[`PSS_ENT_ADDR_MSB:`PSS_ENT_ADDR_LSB];
  wire [7:0] ent_data  = rom_word[`PSS_ENT_DATA_MSB:0];
  // Upset folded into one entry only; spread over the even-sized store it would cancel out
  wire [7:0] chk_upset = (rd_idx_q == '0) ? FUSE_UPSET : 8'h00;
  wire       ent_last  = rom_word[`PSS_ENT_LAST_BIT];
  wire       ent_io    = rom_word[`PSS_ENT_IO_BIT];
  wire       tick      = (tick_q == '0);
  wire       supplied  = POR_OK && LOW_SYSTEM_THRESHOLD_OK;
  wire       powered   = (pwr_q == PSS_OFF) || (pwr_q == PSS_ACTIVE) || (pwr_q == PSS_SLEEP);
  wire       on_ok     = HIGH_SYSTEM_THRESHOLD_OK && !HOT_DIE;
  wire       off_seq   = (seq_q == PSS_SEQ_ACTIVE_TO_OFF_SEQUENCE) || (seq_q == PSS_SEQ_SLEEP_TO_OFF_SEQUENCE);
  wire       off_abort = (ph_q != PSS_PH_IDLE) && OFF_REQ && !off_seq;
  wire [7:0] sig_next  = sig_q ^ ent_addr ^ ent_data ^ chk_upset;
  wire       chk_done  = chk_vld_q && (rd_idx_q == `PSS_ROM_LAST_IDX);
  wire       mismatch  = (sig_next != `PSS_ROM_SIG);

  assign policy = pss_policy_t'(CHECK_POLICY);

  // Which requests make sense in the present state
  assign legal[`PSS_REQ_OFF]   = (pwr_q == PSS_ACTIVE) || (pwr_q == PSS_SLEEP);
  assign legal[`PSS_REQ_WAKE]  = (pwr_q == PSS_SLEEP);
  assign legal[`PSS_REQ_SLEEP] = (pwr_q == PSS_ACTIVE) && !IRQ_PENDING;
  assign legal[`PSS_REQ_ON]    = (pwr_q == PSS_OFF) && on_ok;

  pss_req_arb pss_req_arb_inst (
    .clk   (CORE_CLK),
    .rst_n (RST_N),
    .req   ({ON_REQ, SLEEP_REQ, WAKE_REQ, OFF_REQ}),
    .legal (legal),
    .busy  (ph_q != PSS_PH_IDLE),
    .grant (grant)
  );

  pss_seq_rom pss_seq_rom_inst (
    .clk     (CORE_CLK),
    .addr    (ptr_q),
    .rd_data (rom_word)
  );

  always_comb begin
    pwr_d      = pwr_q;
    seq_d      = seq_q;
    ph_d       = ph_q;
    ptr_d      = ptr_q;
    sig_d      = sig_q;
    io_limit_d = io_limit_q;
    seq_wr     = 1'b0;
    hw_load    = 1'b0;
    err_set    = 1'b0;
    start_run  = 1'b0;
    if (!POR_OK) begin
      pwr_d = PSS_NO_SUPPLY;
      ph_d  = PSS_PH_IDLE;
      seq_d = PSS_SEQ_NONE;
    end else if (!LOW_SYSTEM_THRESHOLD_OK) begin
      pwr_d = PSS_BACKUP;
      ph_d  = PSS_PH_IDLE;
      seq_d = PSS_SEQ_NONE;
    end else if (!powered) begin
      // Entry into off from no-supply or backup is a plain hardware reload, no sequence runs
      pwr_d   = PSS_OFF;
      hw_load = 1'b1;
    end else if (off_abort) begin
      if (ph_q == PSS_PH_CHECK) begin
        ph_d  = PSS_PH_IDLE;
        seq_d = PSS_SEQ_NONE;
      end else begin
        seq_d     = (seq_q == PSS_SEQ_ACTIVE_TO_SLEEP_SEQUENCE) || (pwr_q == PSS_SLEEP) ? PSS_SEQ_SLEEP_TO_OFF_SEQUENCE
                                                                       : PSS_SEQ_ACTIVE_TO_OFF_SEQUENCE;
        ptr_d     = pss_seq_start(seq_d);
        start_run = 1'b1;
        io_limit_d = 1'b0;
      end
    end else begin
      case (ph_q)
        PSS_PH_IDLE: begin
          seq_d = PSS_SEQ_NONE;
          // Grants are rechecked here since conditions may move in one cycle
          if (grant[`PSS_REQ_OFF] && legal[`PSS_REQ_OFF]) begin
            seq_d = (pwr_q == PSS_SLEEP) ? PSS_SEQ_SLEEP_TO_OFF_SEQUENCE : PSS_SEQ_ACTIVE_TO_OFF_SEQUENCE;
          end else if (grant[`PSS_REQ_WAKE] && legal[`PSS_REQ_WAKE]) begin
            seq_d = on_ok ? PSS_SEQ_SLEEP_TO_ACTIVE_SEQUENCE : PSS_SEQ_SLEEP_TO_OFF_SEQUENCE;
          end else if (grant[`PSS_REQ_SLEEP] && legal[`PSS_REQ_SLEEP]) begin
            seq_d = PSS_SEQ_ACTIVE_TO_SLEEP_SEQUENCE;
          end else if (grant[`PSS_REQ_ON] && legal[`PSS_REQ_ON]) begin
            seq_d = PSS_SEQ_OFF_TO_ACTIVE_SEQUENCE;
          end
          io_limit_d = 1'b0;
          if (seq_d == PSS_SEQ_OFF_TO_ACTIVE_SEQUENCE && policy != PSS_POL_SKIP) begin
            ph_d  = PSS_PH_CHECK;
            ptr_d = '0;
            sig_d = 8'h00;
          end else if (seq_d != PSS_SEQ_NONE) begin
            ph_d      = PSS_PH_RUN;
            ptr_d     = pss_seq_start(seq_d);
            start_run = 1'b1;
          end
        end
        PSS_PH_CHECK: begin
          ptr_d = ptr_q + 1'b1;
          if (chk_vld_q) begin
            sig_d = sig_next;
          end
          if (chk_done) begin
            err_set = mismatch;
            if (mismatch && policy == PSS_POL_STOP) begin
              ph_d  = PSS_PH_IDLE;
              seq_d = PSS_SEQ_NONE;
            end else begin
              io_limit_d = mismatch && (policy == PSS_POL_IO_ONLY);
              ph_d       = PSS_PH_RUN;
              ptr_d      = pss_seq_start(seq_q);
              start_run  = 1'b1;
            end
          end
        end
        PSS_PH_RUN: begin
          if (tick) begin
            seq_wr = 1'b1;
            if (ent_last || (io_limit_q && ent_io)) begin
              pwr_d = pss_seq_target(seq_q);
              ph_d  = PSS_PH_IDLE;
              seq_d = PSS_SEQ_NONE;
            end else begin
              ptr_d = ptr_q + 1'b1;
            end
          end
        end
        default: begin
          ph_d = PSS_PH_IDLE;
        end
      endcase
    end
  end

  // Resources written on by the active-to-sleep sequence hold their linked subsystems up through sleep
  always_comb begin
    link_d = LINK_KEEP_ON;
    if (pwr_d != PSS_SLEEP && seq_d != PSS_SEQ_ACTIVE_TO_SLEEP_SEQUENCE) begin
      link_d = 8'h00;
    end else if (seq_wr && seq_q == PSS_SEQ_ACTIVE_TO_SLEEP_SEQUENCE) begin
      link_d[ent_addr[2:0]] = (ent_data[1:0] == `PSS_MODE_ON);
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      pwr_q      <= PSS_NO_SUPPLY;
      seq_q      <= PSS_SEQ_NONE;
      ph_q       <= PSS_PH_IDLE;
      ptr_q      <= '0;
      sig_q      <= 8'h00;
      io_limit_q <= 1'b0;
    end else begin
      pwr_q      <= pwr_d;
      seq_q      <= seq_d;
      ph_q       <= ph_d;
      ptr_q      <= ptr_d;
      sig_q      <= sig_d;
      io_limit_q <= io_limit_d;
    end
  end

  // Store read data lags its address by one cycle
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      rd_idx_q  <= '0;
      chk_vld_q <= 1'b0;
    end else begin
      rd_idx_q  <= ptr_q;
      chk_vld_q <= (ph_q == PSS_PH_CHECK) && (ph_d == PSS_PH_CHECK);
    end
  end

  // Step pacing; the reload gives the store a full tick to settle
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      tick_q <= '0;
    end else if (start_run || tick) begin
      tick_q <= `PSS_TICK_W'(TICK_DIV - 1);
    end else begin
      tick_q <= tick_q - 1'b1;
    end
  end

  // Sequencer writes win; a colliding software write is dropped
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      RES_WR_EN   <= 1'b0;
      RES_WR_ADDR <= 8'h00;
      RES_WR_DATA <= 8'h00;
    end else if (seq_wr) begin
      RES_WR_EN   <= 1'b1;
      RES_WR_ADDR <= ent_addr;
      RES_WR_DATA <= ent_data;
    end else begin
      RES_WR_EN   <= SW_WR_EN && powered && supplied;
      RES_WR_ADDR <= SW_WR_ADDR;
      RES_WR_DATA <= SW_WR_DATA;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      POWER_STATE          <= 3'h0;
      SEQ_BUSY             <= 1'b0;
      RES_DEFAULT_LOAD     <= 1'b0;
      LINK_KEEP_ON         <= 8'h00;
      INTEGRITY_ERROR_FLAG <= 1'b0;
    end else begin
      POWER_STATE          <= pwr_d;
      SEQ_BUSY             <= (ph_d != PSS_PH_IDLE);
      RES_DEFAULT_LOAD     <= hw_load;
      LINK_KEEP_ON         <= link_d;
      // Set beats clear when both land together
      INTEGRITY_ERROR_FLAG <= err_set || (INTEGRITY_ERROR_FLAG && !INTEGRITY_ERROR_CLR);
    end
  end
endmodule
`default_nettype wire

// file: inc/pss_consts.svh
`ifndef PSS_CONSTS_SVH
`define PSS_CONSTS_SVH

// Clocking of the sequencer
`define PSS_CORE_CLK_HZ   250000000
`define PSS_SEQ_OSC_HZ    32768
`define PSS_TICK_DIV      (`PSS_CORE_CLK_HZ / `PSS_SEQ_OSC_HZ)
`define PSS_TICK_W        13

// Sequence store geometry and entry layout {last, io_rail, addr, data}
`define PSS_ROM_DEPTH     32
`define PSS_ROM_AW        5
`define PSS_ROM_LAST_IDX  5'h1F
`define PSS_ENT_W         18
`define PSS_ENT_LAST_BIT  17
`define PSS_ENT_IO_BIT    16
`define PSS_ENT_ADDR_MSB  15
`define PSS_ENT_ADDR_LSB  8
`define PSS_ENT_DATA_MSB  7

// Start of each stored sequence
`define PSS_START_OFF_TO_ACTIVE_SEQUENCE 5'h00
`define PSS_START_ACTIVE_TO_OFF_SEQUENCE 5'h08
`define PSS_START_ACTIVE_TO_SLEEP_SEQUENCE 5'h10
`define PSS_START_SLEEP_TO_ACTIVE_SEQUENCE 5'h16
`define PSS_START_SLEEP_TO_OFF_SEQUENCE 5'h1A

// Resource mode codes in data[1:0]
`define PSS_MODE_OFF      2'h0
`define PSS_MODE_ON       2'h1
`define PSS_MODE_SLEEP    2'h2

// Programmed integrity signature: XOR of addr and data of all entries
`define PSS_ROM_SIG       8'h07

// Request bit positions, highest priority first
`define PSS_REQ_OFF       0
`define PSS_REQ_WAKE      1
`define PSS_REQ_SLEEP     2
`define PSS_REQ_ON        3

`endif

// file: inc/pss_pkg.sv
`default_nettype none
package pss_pkg;
  `include "pss_consts.svh"

  typedef enum logic [2:0] {
    PSS_NO_SUPPLY,
    PSS_BACKUP,
    PSS_OFF,
    PSS_ACTIVE,
    PSS_SLEEP
  } pss_pwr_t;

  typedef enum logic [2:0] {
    PSS_SEQ_NONE,
    PSS_SEQ_OFF_TO_ACTIVE_SEQUENCE,
    PSS_SEQ_ACTIVE_TO_OFF_SEQUENCE,
    PSS_SEQ_ACTIVE_TO_SLEEP_SEQUENCE,
    PSS_SEQ_SLEEP_TO_ACTIVE_SEQUENCE,
    PSS_SEQ_SLEEP_TO_OFF_SEQUENCE
  } pss_seq_t;

  typedef enum logic [1:0] {
    PSS_PH_IDLE,
    PSS_PH_CHECK,
    PSS_PH_RUN
  } pss_phase_t;

  typedef enum logic [1:0] {
    PSS_POL_SKIP,
    PSS_POL_CONTINUE,
    PSS_POL_IO_ONLY,
    PSS_POL_STOP
  } pss_policy_t;

  function automatic logic [`PSS_ROM_AW-1:0] pss_seq_start(input pss_seq_t s);
    case (s)
      PSS_SEQ_ACTIVE_TO_OFF_SEQUENCE: pss_seq_start = `PSS_START_ACTIVE_TO_OFF_SEQUENCE;
      PSS_SEQ_ACTIVE_TO_SLEEP_SEQUENCE: pss_seq_start = `PSS_START_ACTIVE_TO_SLEEP_SEQUENCE;
      PSS_SEQ_SLEEP_TO_ACTIVE_SEQUENCE: pss_seq_start = `PSS_START_SLEEP_TO_ACTIVE_SEQUENCE;
      PSS_SEQ_SLEEP_TO_OFF_SEQUENCE: pss_seq_start = `PSS_START_SLEEP_TO_OFF_SEQUENCE;
      default:         pss_seq_start = `PSS_START_OFF_TO_ACTIVE_SEQUENCE;
    endcase
  endfunction

  function automatic pss_pwr_t pss_seq_target(input pss_seq_t s);
    case (s)
      PSS_SEQ_OFF_TO_ACTIVE_SEQUENCE, PSS_SEQ_SLEEP_TO_ACTIVE_SEQUENCE: pss_seq_target = PSS_ACTIVE;
      PSS_SEQ_ACTIVE_TO_SLEEP_SEQUENCE:                  pss_seq_target = PSS_SLEEP;
      default:                          pss_seq_target = PSS_OFF;
    endcase
  endfunction
endpackage
`default_nettype wire

// file: hw/pss_seq_rom.sv
`timescale 1ns/1ns
`default_nettype none
`include "pss_consts.svh"
// Fixed sequence store; no write port exists, so contents cannot change
module pss_seq_rom
  import pss_pkg::*;
(
  input  wire logic                  clk,
  input  wire logic [`PSS_ROM_AW-1:0] addr,
  output logic      [`PSS_ENT_W-1:0]  rd_data
);
  logic [`PSS_ENT_W-1:0] word;

  always_comb begin
    case (addr)
      5'h00:   word = 18'h0_0101;
      5'h01:   word = 18'h1_0201;
      5'h02:   word = 18'h0_0301;
      5'h03:   word = 18'h2_0401;
      5'h08:   word = 18'h0_0400;
      5'h09:   word = 18'h0_0300;
      5'h0A:   word = 18'h1_0200;
      5'h0B:   word = 18'h2_0100;
      5'h10:   word = 18'h0_0302;
      5'h11:   word = 18'h2_0401;
      5'h16:   word = 18'h0_0301;
      5'h17:   word = 18'h2_0401;
      5'h1A:   word = 18'h0_0400;
      5'h1B:   word = 18'h0_0300;
      5'h1C:   word = 18'h1_0200;
      5'h1D:   word = 18'h2_0100;
      default: word = 18'h0_0000;
    endcase
  end

  always_ff @(posedge clk) begin
    rd_data <= word;
  end
endmodule
`default_nettype wire

// file: hw/pss_req_arb.sv
`timescale 1ns/1ns
`default_nettype none
module pss_req_arb
  import pss_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic [3:0] req,
  input  wire logic [3:0] legal,
  input  wire logic       busy,
  output logic      [3:0] grant
);
  logic [3:0] pend_q;
  logic [3:0] pend_d;
  logic [3:0] cand;
  logic [3:0] pick;
  logic       may_grant;

  // Held requests are only judged once the sequencer is idle again
  assign may_grant = !busy && (grant == 4'h0);
  assign cand      = pend_q & legal;
  // Fixed priority: off, wake, sleep, on
  assign pick      = cand & (~cand + 4'h1);

  always_comb begin
    pend_d = pend_q;
    if (may_grant) begin
      pend_d = cand & ~pick;
    end
    // New arrivals win over the clear in the same cycle
    pend_d = pend_d | req;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pend_q <= 4'h0;
      grant  <= 4'h0;
    end else begin
      pend_q <= pend_d;
      grant  <= may_grant ? pick : 4'h0;
    end
  end
endmodule
`default_nettype wire

// file: bench/pss_top_props.sv
`timescale 1ns/1ns
`default_nettype none
module pss_top_props #(
  parameter int unsigned TICK_DIV = 7629
)
(
  input wire logic       CORE_CLK,
  input wire logic       RST_N,
  input wire logic       POR_OK,
  input wire logic       LOW_SYSTEM_THRESHOLD_OK,
  input wire logic       HIGH_SYSTEM_THRESHOLD_OK,
  input wire logic       HOT_DIE,
  input wire logic       ON_REQ,
  input wire logic       OFF_REQ,
  input wire logic       SLEEP_REQ,
  input wire logic       WAKE_REQ,
  input wire logic       IRQ_PENDING,
  input wire logic [1:0] CHECK_POLICY,
  input wire logic [7:0] FUSE_UPSET,
  input wire logic       INTEGRITY_ERROR_CLR,
  input wire logic       SW_WR_EN,
  input wire logic [7:0] SW_WR_ADDR,
  input wire logic [7:0] SW_WR_DATA,
  input wire logic [2:0] POWER_STATE,
  input wire logic       SEQ_BUSY,
  input wire logic       RES_WR_EN,
  input wire logic [7:0] RES_WR_ADDR,
  input wire logic [7:0] RES_WR_DATA,
  input wire logic       RES_DEFAULT_LOAD,
  input wire logic [7:0] LINK_KEEP_ON,
  input wire logic       INTEGRITY_ERROR_FLAG
);
  logic [15:0] gap_q;
  logic        seen_q;

  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!RST_N);

  // Gap counter only judged between writes of one sequence, so the first write is free
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      gap_q  <= 16'h0000;
      seen_q <= 1'b0;
    end else begin
      gap_q  <= RES_WR_EN ? 16'h0000 : gap_q + 16'h0001;
      seen_q <= SEQ_BUSY & (seen_q | RES_WR_EN);
    end
  end

  chk_nosup_state: assert property (!POR_OK |=> POWER_STATE == 3'h0)
    else $error("state not no-supply after supply loss");
  chk_backup_state: assert property (POR_OK && !LOW_SYSTEM_THRESHOLD_OK |=> POWER_STATE == 3'h1)
    else $error("state not backup below low threshold");
  chk_default_load: assert property (RES_DEFAULT_LOAD == (POWER_STATE == 3'h2 && $past(POWER_STATE) < 3'h2))
    else $error("default load pulse does not match hardware entry to off");
  chk_sleep_source: assert property (POWER_STATE == 3'h4 && $past(POWER_STATE) != 3'h4 |-> $past(POWER_STATE) == 3'h3)
    else $error("sleep entered from a state other than active");
  chk_move_by_write: assert property (POWER_STATE inside {3'h3, 3'h4} && POWER_STATE != $past(POWER_STATE)
                                      |-> RES_WR_EN)
    else $error("state moved without a final resource write");
  chk_quiet_low: assert property (POWER_STATE < 3'h2 && $past(POWER_STATE) < 3'h2 |-> !RES_WR_EN && !SEQ_BUSY)
    else $error("sequencer active without supply");
  chk_tick_gap: assert property (RES_WR_EN && SEQ_BUSY && seen_q |-> gap_q == 16'(TICK_DIV - 1))
    else $error("sequence writes not one tick apart");
  chk_flag_hold: assert property (INTEGRITY_ERROR_FLAG && !INTEGRITY_ERROR_CLR |=> INTEGRITY_ERROR_FLAG)
    else $error("integrity flag dropped without clear");
  chk_link_clear: assert property (POWER_STATE != 3'h4 && $past(POWER_STATE) != 3'h4 |-> LINK_KEEP_ON == 8'h00)
    else $error("keep-on bits set outside sleep");
  chk_sw_pass: assert property (SW_WR_EN && POWER_STATE >= 3'h2 && !SEQ_BUSY |=> RES_WR_EN
                                && RES_WR_ADDR == $past(SW_WR_ADDR) && RES_WR_DATA == $past(SW_WR_DATA))
    else $error("software write not passed to resources");
  chk_off_start: assert property (OFF_REQ && POWER_STATE == 3'h3 && !SEQ_BUSY |-> ##[2:4] SEQ_BUSY)
    else $error("off request did not start a sequence");
endmodule

bind pss_top pss_top_props #(.TICK_DIV(TICK_DIV)) pss_top_props_inst (.*);
`default_nettype wire

// file: bench/pss_res_model.sv
`timescale 1ns/1ns
`default_nettype none
module pss_res_model (
  input wire logic       clk,
  input wire logic       wr_en,
  input wire logic [7:0] wr_addr,
  input wire logic [7:0] wr_data,
  input wire logic       default_load
);
  logic [1:0]  res_mode [0:255];
  logic [15:0] wr_log   [$];

  // Resources change by register writes and by the default reload to off on entry to off from no-supply or backup
  always @(posedge clk) begin
    if (default_load) begin
      foreach (res_mode[i]) begin
        res_mode[i] = 2'h0;
      end
    end
    if (wr_en) begin
      res_mode[wr_addr] = wr_data[1:0];
      wr_log.push_back({wr_addr, wr_data});
    end
  end
endmodule
`default_nettype wire

// file: bench/pss_top_test.sv
`timescale 1ns/1ns
`default_nettype none
module pss_top_test;
  localparam int unsigned TDIV = 6;
  localparam logic [3:0] R_OFF = 4'h1;
  localparam logic [3:0] R_WAKE = 4'h2;
  localparam logic [3:0] R_SLP = 4'h4;
  localparam logic [3:0] R_ON = 4'h8;
  localparam logic [63:0] UP = 64'h0101_0201_0301_0401;
  localparam logic [63:0] DN = 64'h0400_0300_0200_0100;
  logic       clk, rst_n, por_ok, lo_ok, hi_ok, hot, irq, clr, sw_en;
  logic       busy, wr_en, dload, flag;
  logic [3:0] req;
  logic [1:0] pol;
  logic [2:0] state;
  logic [7:0] fuse, sw_addr, sw_data, wr_addr, wr_data, keep;
  int         n_mismatch, n_tests;

  pss_top #(.TICK_DIV(TDIV)) pss_top_inst (
    .CORE_CLK(clk), .RST_N(rst_n), .POR_OK(por_ok), .LOW_SYSTEM_THRESHOLD_OK(lo_ok),
    .HIGH_SYSTEM_THRESHOLD_OK(hi_ok), .HOT_DIE(hot), .ON_REQ(req[3]), .OFF_REQ(req[0]),
    .SLEEP_REQ(req[2]), .WAKE_REQ(req[1]), .IRQ_PENDING(irq), .CHECK_POLICY(pol),
    .FUSE_UPSET(fuse), .INTEGRITY_ERROR_CLR(clr), .SW_WR_EN(sw_en), .SW_WR_ADDR(sw_addr),
    .SW_WR_DATA(sw_data), .POWER_STATE(state), .SEQ_BUSY(busy), .RES_WR_EN(wr_en),
    .RES_WR_ADDR(wr_addr), .RES_WR_DATA(wr_data), .RES_DEFAULT_LOAD(dload),
    .LINK_KEEP_ON(keep), .INTEGRITY_ERROR_FLAG(flag));

  pss_res_model pss_res_model_inst (
    .clk(clk), .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data), .default_load(dload));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic close_out();
    $display("checks %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic fire(input logic [3:0] m);
    @(posedge clk);
    req <= m;
    @(posedge clk);
    req <= 4'h0;
    #1;
  endtask

  // Refused requests must not raise busy within 8 cycles; accepted ones are timed out, not waited on forever
  task automatic run(input logic [3:0] m, input logic go, input int n, input logic [63:0] w,
                     input logic [2:0] st);
    int k;
    pss_res_model_inst.wr_log.delete();
    fire(m);
    for (k = 0; k < 8 && busy !== 1'b1; k++) begin
      cyc(1);
    end
    chk_val(16'(busy), 16'(go));
    for (k = 0; k < 600 && busy !== 1'b0; k++) begin
      cyc(1);
    end
    if (k == 600) begin
      n_mismatch++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, busy, 1'b0);
      close_out();
    end
    cyc(2);
    chk_val(16'(state), 16'(st));
    chk_val(16'(pss_res_model_inst.wr_log.size()), 16'(n));
    for (int i = 0; i < n; i++) begin
      chk_val(pss_res_model_inst.wr_log[i], w[63 - 16 * i -: 16]);
    end
  endtask

  task automatic t_supply();
    cyc(3);
    chk_val(16'(state), 16'h0000);
    por_ok <= 1'b1;
    cyc(3);
    chk_val(16'(state), 16'h0001);
    lo_ok <= 1'b1;
    cyc(1);
    chk_val(16'(dload), 16'h0001);
    chk_val(16'(state), 16'h0002);
    cyc(1);
    chk_val(16'(dload), 16'h0000);
    chk_val(16'(pss_res_model_inst.res_mode[7]), 16'h0000);
  endtask

  task automatic t_gated();
    hi_ok <= 1'b1;
    hot <= 1'b1;
    run(R_ON, 1'b0, 0, UP, 3'h2);
    hot <= 1'b0;
    hi_ok <= 1'b0;
    run(R_ON, 1'b0, 0, UP, 3'h2);
    hi_ok <= 1'b1;
    run(R_WAKE, 1'b0, 0, UP, 3'h2);
    run(R_SLP, 1'b0, 0, UP, 3'h2);
  endtask

  // One power-up request per check policy, each with an upset stored bit
  task automatic t_policy();
    logic [1:0] nw [4] = '{2'd0, 2'd0, 2'd2, 2'd0};
    fuse <= 8'h01;
    for (int p = 0; p < 4; p++) begin
      pol <= 2'(p);
      run(R_ON, 1'b1, (p < 2) ? 4 : int'(nw[p]), UP, (p == 3) ? 3'h2 : 3'h3);
      chk_val(16'(flag), (p == 0) ? 16'h0000 : 16'h0001);
      if (p != 3) begin
        run(R_OFF, 1'b1, 4, DN, 3'h2);
      end
      clr <= 1'b1;
      cyc(1);
      clr <= 1'b0;
      cyc(2);
      chk_val(16'(flag), 16'h0000);
    end
    pol <= 2'h0;
    fuse <= 8'h00;
  endtask

  task automatic t_sleep();
    run(R_ON, 1'b1, 4, UP, 3'h3);
    run(R_WAKE, 1'b0, 0, UP, 3'h3);
    irq <= 1'b1;
    run(R_SLP, 1'b0, 0, UP, 3'h3);
    irq <= 1'b0;
    run(R_SLP, 1'b1, 2, 64'h0302_0401_0000_0000, 3'h4);
    chk_val(16'(keep), 16'h0010);
    chk_val(16'(pss_res_model_inst.res_mode[3]), 16'h0002);
    run(R_WAKE, 1'b1, 2, 64'h0301_0401_0000_0000, 3'h3);
    chk_val(16'(keep), 16'h0000);
    run(R_SLP, 1'b1, 2, 64'h0302_0401_0000_0000, 3'h4);
    hot <= 1'b1;
    run(R_WAKE, 1'b1, 4, DN, 3'h2);
    hot <= 1'b0;
    run(R_ON, 1'b1, 4, UP, 3'h3);
    run(R_OFF | R_SLP | R_ON, 1'b1, 4, DN, 3'h2);
  endtask

  task automatic t_cancel_sw();
    pol <= 2'h1;
    pss_res_model_inst.wr_log.delete();
    fire(R_ON);
    cyc(8);
    chk_val(16'(busy), 16'h0001);
    run(R_OFF, 1'b0, 0, UP, 3'h2);
    pol <= 2'h0;
    @(posedge clk);
    sw_en <= 1'b1;
    sw_addr <= 8'h05;
    sw_data <= 8'h01;
    @(posedge clk);
    sw_en <= 1'b0;
    #1;
    chk_val({7'h00, wr_en, wr_addr}, 16'h0105);
    chk_val(16'(wr_data), 16'h0001);
    lo_ok <= 1'b0;
    cyc(3);
    chk_val(16'(state), 16'h0001);
  endtask

  initial begin
    n_mismatch = 0;
    n_tests = 0;
    {rst_n, por_ok, lo_ok, hi_ok, hot, irq, clr, sw_en} = 8'h00;
    req = 4'h0;
    pol = 2'h0;
    {fuse, sw_addr, sw_data} = 24'h00_0000;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    t_supply();
    t_gated();
    t_policy();
    t_sleep();
    t_cancel_sw();
    close_out();
  end
endmodule
`default_nettype wire
